// [core/cafb_bank.sv]
`timescale 1ns/1ps
module cafb_bank
	import cafb_pkg::*;
(
	input wire logic [CAFB_BANK_BYTES-1:0][7:0] bank_bytes,
	input wire logic [1:0] bank_scale_field,
	input wire logic filter_active_bit,
	input wire logic low_half_mode_bit,
	input wire logic high_half_mode_bit,
	input wire cafb_frame_s frame,
	output cafb_cand_s cand
);

	logic [31:0] w32;
	logic [31:0] w16;
	logic [31:0] w8;

	function automatic logic [31:0] pair16(logic [7:0] hi, logic [7:0] lo);
		return {16'h0000, hi, lo};
	endfunction

	function automatic logic [31:0] one8(logic [7:0] v);
		return {24'h00_0000, v};
	endfunction

	function automatic cafb_cand_s offer(cafb_cand_s cur, logic [1:0] hits,
		logic list, logic [1:0] cov, logic [2:0] ra, logic [2:0] rb);
		cafb_cand_s n;
		n.hit = |hits;
		n.list = list;
		n.cov = cov;
		// first register wins inside a slot
		n.reg_idx = hits[0] ? ra : rb;
		return cafb_better(n, cur) ? n : cur;
	endfunction

	always_comb
	begin
		logic [7:0][7:0] b;
		cafb_cand_s c;
		b = bank_bytes;
		c = '0;
		// std 10:3 | std 2:0 rtr ide ext 17:15 | ext 14:7 | ext 6:0 -
		w32 = {frame.std_id, frame.rtr, frame.ide, frame.ext_id, 1'b0};
		w16 = {16'h0000, frame.std_id, frame.rtr, frame.ide,
			frame.ext_id[17:15]};
		w8 = {24'h00_0000, frame.std_id[10:3]};
		unique case (bank_scale_field)
			CAFB_SCALE_32:
			begin
				// the whole 32-bit filter follows the low half mode bit
				c = offer(c, cafb_slot({b[0], b[1], b[2], b[3]},
					{b[4], b[5], b[6], b[7]}, w32, CAFB_CARE_32,
					low_half_mode_bit), low_half_mode_bit, CAFB_COV_32,
					3'h0, 3'h4);
			end
			CAFB_SCALE_16:
			begin
				c = offer(c, cafb_slot(pair16(b[0], b[1]), pair16(b[2], b[3]),
					w16, CAFB_CARE_16, low_half_mode_bit),
					low_half_mode_bit, CAFB_COV_16, 3'h0, 3'h2);
				c = offer(c, cafb_slot(pair16(b[4], b[5]), pair16(b[6], b[7]),
					w16, CAFB_CARE_16, high_half_mode_bit),
					high_half_mode_bit, CAFB_COV_16, 3'h4, 3'h6);
			end
			CAFB_SCALE_MIX:
			begin
				c = offer(c, cafb_slot(pair16(b[0], b[1]), pair16(b[2], b[3]),
					w16, CAFB_CARE_16, low_half_mode_bit),
					low_half_mode_bit, CAFB_COV_16, 3'h0, 3'h2);
				c = offer(c, cafb_slot(one8(b[4]), one8(b[5]), w8, CAFB_CARE_8,
					high_half_mode_bit), high_half_mode_bit, CAFB_COV_8,
					3'h4, 3'h5);
				c = offer(c, cafb_slot(one8(b[6]), one8(b[7]), w8, CAFB_CARE_8,
					high_half_mode_bit), high_half_mode_bit, CAFB_COV_8,
					3'h6, 3'h7);
			end
			CAFB_SCALE_8:
			begin
				c = offer(c, cafb_slot(one8(b[0]), one8(b[1]), w8, CAFB_CARE_8,
					low_half_mode_bit), low_half_mode_bit, CAFB_COV_8,
					3'h0, 3'h1);
				c = offer(c, cafb_slot(one8(b[2]), one8(b[3]), w8, CAFB_CARE_8,
					low_half_mode_bit), low_half_mode_bit, CAFB_COV_8,
					3'h2, 3'h3);
				c = offer(c, cafb_slot(one8(b[4]), one8(b[5]), w8, CAFB_CARE_8,
					high_half_mode_bit), high_half_mode_bit, CAFB_COV_8,
					3'h4, 3'h5);
				c = offer(c, cafb_slot(one8(b[6]), one8(b[7]), w8, CAFB_CARE_8,
					high_half_mode_bit), high_half_mode_bit, CAFB_COV_8,
					3'h6, 3'h7);
			end
		endcase
		// no snapshot of the settings: they are stable while active
		if (!filter_active_bit)
			c = '0;
		cand = c;
	end

endmodule

// [core/cafb_pkg.sv]
// What this block does
// - six filter banks, numbered zero to five
// - each bank holds eight software byte registers
// - every bank picks its scale independently
// - 32-bit scale compares std, ide, ext, rtr
// - 32-bit byte layout: std, flags, ext bits
// - 16-bit scale: two filters, std rtr ide
// - 8-bit scale: four filters on std 10:3
// - mixed scale: one 16-bit, two 8-bit filters
// - scale code 3, 2, 0 pick 32/16/8
// - mask mode compares only must-match bits
// - list mode uses masks as identifiers
// - list match needs every compared bit equal
// - frame matching no filter is dropped
// - two mode bits per bank, low/high half
// - list beats mask, wider beats narrower
// - ties go to lowest bank and register
package cafb_pkg;

	localparam int CAFB_MAX_BANKS = 6;
	localparam int CAFB_BANK_BYTES = 8;
	localparam int CAFB_INDEX_W = 6;

	localparam logic [7:0] CAFB_ADDR_SCALE = 8'h30;
	localparam logic [7:0] CAFB_ADDR_ACTIVE = 8'h34;
	localparam logic [7:0] CAFB_ADDR_MODE = 8'h38;
	localparam logic [7:0] CAFB_ADDR_STATUS = 8'h3C;
	localparam logic [7:0] CAFB_ADDR_COUNT = 8'h40;

	localparam int CAFB_MODE_HI_LSB = 8;
	localparam int CAFB_STAT_ACCEPT = 8;
	localparam int CAFB_STAT_SEEN = 9;
	localparam int CAFB_STAT_LIST = 10;
	localparam int CAFB_STAT_COV_LSB = 12;
	localparam int CAFB_CNT_DROP_LSB = 8;

	localparam logic [1:0] CAFB_SCALE_32 = 2'h3;
	localparam logic [1:0] CAFB_SCALE_16 = 2'h2;
	localparam logic [1:0] CAFB_SCALE_MIX = 2'h1;
	localparam logic [1:0] CAFB_SCALE_8 = 2'h0;

	localparam logic [1:0] CAFB_COV_32 = 2'h3;
	localparam logic [1:0] CAFB_COV_16 = 2'h2;
	localparam logic [1:0] CAFB_COV_8 = 2'h1;

	// bit 0 of the 32-bit word has no identifier bit behind it
	localparam logic [31:0] CAFB_CARE_32 = 32'hFFFF_FFFE;
	// ext 17:15 share the 16-bit byte but are not compared
	localparam logic [31:0] CAFB_CARE_16 = 32'h0000_FFF8;
	localparam logic [31:0] CAFB_CARE_8 = 32'h0000_00FF;

	localparam logic [7:0] CAFB_RST_BYTE = 8'h00;
	localparam logic [1:0] CAFB_RST_SCALE = CAFB_SCALE_8;

	typedef struct packed {
		logic [10:0] std_id;
		logic [17:0] ext_id;
		logic ide;
		logic rtr;
	} cafb_frame_s;

	typedef struct packed {
		logic hit;
		logic list;
		logic [1:0] cov;
		logic [2:0] reg_idx;
	} cafb_cand_s;

	typedef struct packed {
		logic valid;
		logic accept;
		logic [CAFB_INDEX_W-1:0] index;
		logic list;
		logic [1:0] cov;
	} cafb_result_s;

	typedef struct packed {
		logic [7:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} cafb_avm_req_s;

	// strict order only, so an equal candidate never displaces an earlier one
	function automatic logic cafb_better(cafb_cand_s n, cafb_cand_s c);
		return n.hit && (!c.hit || ({n.list, n.cov} > {c.list, c.cov}));
	endfunction

	// bit 0: first register matched, bit 1: second register matched
	function automatic logic [1:0] cafb_slot(logic [31:0] a, logic [31:0] b,
		logic [31:0] f, logic [31:0] care, logic list);
		logic [1:0] r;
		r = 2'h0;
		if (list)
		begin
			r[0] = (((a ^ f) & care) == 32'h0000_0000);
			r[1] = (((b ^ f) & care) == 32'h0000_0000);
		end
		else
		begin
			r[0] = (((a ^ f) & b & care) == 32'h0000_0000);
		end
		return r;
	endfunction

endpackage

// [core/cafb_top.sv]
`timescale 1ns/1ps
module cafb_top
	import cafb_pkg::*;
#(
	parameter int NUM_BANKS = CAFB_MAX_BANKS
)
(
	input wire logic clock,
	input wire logic rst_n,
	input wire cafb_avm_req_s avm_req,
	output logic [31:0] avm_readdata,
	output logic avm_waitrequest,
	input wire logic frame_valid,
	input wire cafb_frame_s frame,
	output cafb_result_s result
);

	// index carries only three bank bits; the map ends below the config words
	if (NUM_BANKS < 1 || NUM_BANKS > CAFB_MAX_BANKS)
	begin : g_bad_banks
		$error("cafb_top: NUM_BANKS must be 1 to 6");
	end

	localparam logic [7:0] BANK_SPAN = 8'(NUM_BANKS * CAFB_BANK_BYTES);

	typedef struct packed {
		logic [NUM_BANKS-1:0][CAFB_BANK_BYTES-1:0][7:0] fbytes;
		logic [NUM_BANKS-1:0][1:0] scale;
		logic [NUM_BANKS-1:0] active;
		logic [NUM_BANKS-1:0] mode_lo;
		logic [NUM_BANKS-1:0] mode_hi;
		logic ack;
		logic [31:0] rdata;
		cafb_result_s res;
		logic seen;
		logic [7:0] acc_cnt;
		logic [7:0] drop_cnt;
	} cafb_state_s;

	cafb_state_s q;
	cafb_state_s d;
	cafb_cand_s cands [NUM_BANKS];
	cafb_cand_s best;
	logic [CAFB_INDEX_W-1:0] best_index;
	logic req_act;
	logic [4:0] bsel;
	logic half;
	logic [31:0] rd;
	logic [31:0] wm;

	for (genvar g = 0; g < NUM_BANKS; g++)
	begin : g_bank
		cafb_bank u_bank (
			.bank_bytes(q.fbytes[g]),
			.bank_scale_field(q.scale[g]),
			.filter_active_bit(q.active[g]),
			.low_half_mode_bit(q.mode_lo[g]),
			.high_half_mode_bit(q.mode_hi[g]),
			.frame(frame),
			.cand(cands[g])
		);
	end

	// banks are scanned upward so an equal later candidate never wins
	always_comb
	begin
		best = '0;
		best_index = '0;
		for (int i = 0; i < NUM_BANKS; i++)
		begin
			if (cafb_better(cands[i], best))
			begin
				best = cands[i];
				best_index = {3'(i), cands[i].reg_idx};
			end
		end
	end

	assign req_act = avm_req.read | avm_req.write;
	assign bsel = avm_req.address[7:3];
	assign half = avm_req.address[2];

	// current contents of the addressed word, also the base of a write
	always_comb
	begin
		rd = 32'h0000_0000;
		if (avm_req.address < BANK_SPAN)
		begin
			for (int k = 0; k < 4; k++)
			begin
				rd[8*k +: 8] = q.fbytes[bsel][{half, 2'(k)}];
			end
		end
		else
		begin
			unique case ({avm_req.address[7:2], 2'b00})
				CAFB_ADDR_SCALE:
				begin
					rd[2*NUM_BANKS-1:0] = q.scale;
				end
				CAFB_ADDR_ACTIVE:
				begin
					rd[NUM_BANKS-1:0] = q.active;
				end
				CAFB_ADDR_MODE:
				begin
					rd[NUM_BANKS-1:0] = q.mode_lo;
					rd[CAFB_MODE_HI_LSB +: NUM_BANKS] = q.mode_hi;
				end
				CAFB_ADDR_STATUS:
				begin
					rd[CAFB_INDEX_W-1:0] = q.res.index;
					rd[CAFB_STAT_ACCEPT] = q.res.accept;
					rd[CAFB_STAT_SEEN] = q.seen;
					rd[CAFB_STAT_LIST] = q.res.list;
					rd[CAFB_STAT_COV_LSB +: 2] = q.res.cov;
				end
				CAFB_ADDR_COUNT:
				begin
					rd[7:0] = q.acc_cnt;
					rd[CAFB_CNT_DROP_LSB +: 8] = q.drop_cnt;
				end
				default:
				begin
					rd = 32'h0000_0000;
				end
			endcase
		end
	end

	always_comb
	begin
		wm = rd;
		for (int k = 0; k < 4; k++)
		begin
			if (avm_req.byteenable[k])
				wm[8*k +: 8] = avm_req.writedata[8*k +: 8];
		end
	end

	always_comb
	begin
		d = q;
		d.res.valid = 1'b0;
		// one wait cycle: data is latched here, the write lands next edge
		d.ack = req_act & ~q.ack;
		if (req_act & ~q.ack)
			d.rdata = rd;
		if (avm_req.write & q.ack)
		begin
			if (avm_req.address < BANK_SPAN)
			begin
				for (int k = 0; k < 4; k++)
				begin
					d.fbytes[bsel][{half, 2'(k)}] = wm[8*k +: 8];
				end
			end
			else
			begin
				unique case ({avm_req.address[7:2], 2'b00})
					CAFB_ADDR_SCALE:
					begin
						d.scale = wm[2*NUM_BANKS-1:0];
					end
					CAFB_ADDR_ACTIVE:
					begin
						d.active = wm[NUM_BANKS-1:0];
					end
					CAFB_ADDR_MODE:
					begin
						d.mode_lo = wm[NUM_BANKS-1:0];
						d.mode_hi = wm[CAFB_MODE_HI_LSB +: NUM_BANKS];
					end
					default:
					begin
						d.seen = q.seen;
					end
				endcase
			end
		end
		if (frame_valid)
		begin
			d.res.valid = 1'b1;
			d.res.accept = best.hit;
			d.res.index = best.hit ? best_index : '0;
			d.res.list = best.hit & best.list;
			d.res.cov = best.hit ? best.cov : 2'h0;
			d.seen = 1'b1;
			// counters wrap; software reads differences
			if (best.hit)
				d.acc_cnt = q.acc_cnt + 8'h01;
			else
				d.drop_cnt = q.drop_cnt + 8'h01;
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			q.fbytes <= {(NUM_BANKS * CAFB_BANK_BYTES){CAFB_RST_BYTE}};
			q.scale <= {NUM_BANKS{CAFB_RST_SCALE}};
			q.active <= '0;
			q.mode_lo <= '0;
			q.mode_hi <= '0;
			q.ack <= 1'b0;
			q.rdata <= 32'h0000_0000;
			q.res <= '0;
			q.seen <= 1'b0;
			q.acc_cnt <= 8'h00;
			q.drop_cnt <= 8'h00;
		end
		else
		begin
			q <= d;
		end
	end

	assign avm_readdata = q.rdata;
	assign avm_waitrequest = req_act & ~q.ack;
	assign result = q.res;

endmodule

// [tb/cafb_node.sv]
`timescale 1ns/1ps
module cafb_node
	import cafb_pkg::*;
(
	input wire logic clock,
	output logic frame_valid,
	output cafb_frame_s frame
);
	initial
	begin
		frame_valid = 1'b0;
		frame = 31'h0;
	end
	// idle fields inverted so a stale frame never looks valid
	task automatic send(input cafb_frame_s f);
		@(posedge clock);
		frame_valid <= 1'b1;
		frame <= f;
		@(posedge clock);
		frame_valid <= 1'b0;
		frame <= ~f;
	endtask
endmodule

// [tb/cafb_top_properties.sv]
`timescale 1ns/1ps
module cafb_top_properties
	import cafb_pkg::*;
#(
	parameter int NUM_BANKS = CAFB_MAX_BANKS
)
(
	input wire logic clock,
	input wire logic rst_n,
	input wire cafb_avm_req_s avm_req,
	input wire logic [31:0] avm_readdata,
	input wire logic avm_waitrequest,
	input wire logic frame_valid,
	input wire cafb_frame_s frame,
	input wire cafb_result_s result
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	wire logic req = avm_req.read | avm_req.write;
	wire logic rv = result.valid;
	a_wait_first: assert property (req && !$past(req) |-> avm_waitrequest)
		else $error("no wait cycle");
	a_wait_once: assert property (req && avm_waitrequest
		|=> !avm_waitrequest)
		else $error("wait too long");
	a_frame_answer: assert property (frame_valid |=> rv)
		else $error("no result");
	a_no_spurious: assert property (rv |-> $past(frame_valid))
		else $error("spurious result");
	a_drop_clean: assert property (rv && !result.accept |->
		result.index == 6'h00 && result.cov == 2'h0 && !result.list)
		else $error("drop not clean");
	a_bank_range: assert property (rv && result.accept |->
		result.cov != 2'h0 && result.index[5:3] < NUM_BANKS)
		else $error("bad bank");
	a_wide_reg: assert property (rv && result.cov == 2'h3 |->
		result.index[1:0] == 2'h0)
		else $error("bad wide reg");
	a_mask_even: assert property (rv && result.accept && !result.list |->
		!result.index[0])
		else $error("mask odd reg");
	a_hold_result: assert property (!frame_valid |=>
		$stable(result.accept) && $stable(result.index))
		else $error("result moved");
	c_list: cover property (rv && result.list);
	c_drop: cover property (rv && !result.accept);
	c_wide: cover property (rv && result.cov == 2'h3);
endmodule
bind cafb_top cafb_top_properties #(.NUM_BANKS(NUM_BANKS)) chk (
	.clock(clock), .rst_n(rst_n), .avm_req(avm_req),
	.avm_readdata(avm_readdata), .avm_waitrequest(avm_waitrequest),
	.frame_valid(frame_valid), .frame(frame), .result(result));

// [tb/tb.sv]
`timescale 1ns/1ps
module tb
	import cafb_pkg::*;
;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	cafb_avm_req_s req;
	logic [31:0] rdata;
	logic [31:0] rd;
	logic wreq;
	logic fv;
	cafb_frame_s fr;
	cafb_result_s res;
	int error_cnt = 0;
	int compares = 0;
	int cyc = 0;
	cafb_frame_s f_a = {11'h123, 18'h00000, 1'b0, 1'b0};
	cafb_frame_s f_g = {11'h7FF, 18'h00000, 1'b0, 1'b0};
	cafb_frame_s f_h = {11'h124, 18'h00000, 1'b0, 1'b0};
	cafb_frame_s f_e = {11'h555, 18'h2ABCD, 1'b1, 1'b1};
	cafb_frame_s f_x = {11'h555, 18'h2ABCC, 1'b1, 1'b1};
	always #5 clock = ~clock;
	cafb_top #(.NUM_BANKS(6)) uut (.clock(clock), .rst_n(rst_n),
		.avm_req(req), .avm_readdata(rdata), .avm_waitrequest(wreq),
		.frame_valid(fv), .frame(fr), .result(res));
	cafb_node node (.clock(clock), .frame_valid(fv), .frame(fr));
	task automatic stop_test;
		if (error_cnt == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		compares++;
		if (s !== e)
		begin
			error_cnt++;
			$display("MISMATCH %s exp %h got %h", n, e, s);
		end
	endtask
	// byte k of the bank sits in lane k
	function automatic logic [31:0] pw(cafb_frame_s f);
		logic [31:0] v;
		v = {f.std_id, f.rtr, f.ide, f.ext_id, 1'b0};
		return {v[7:0], v[15:8], v[23:16], v[31:24]};
	endfunction
	task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge clock);
		req.address <= a;
		req.write <= w;
		req.read <= !w;
		req.writedata <= d;
		// no fixed latency assumed; the cycle ceiling ends a hung wait
		do
		begin
			@(posedge clock);
		end
		while (wreq !== 1'b0);
		rd = rdata;
		req.write <= 1'b0;
		req.read <= 1'b0;
	endtask
	task automatic rchk(string n, logic [7:0] a, logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(n, rd, e);
	endtask
	task automatic fchk(cafb_frame_s f, logic a, logic [5:0] i,
		logic [1:0] c, logic l);
		node.send(f);
		#1;
		chk("valid", res.valid, 32'h1);
		chk("accept", res.accept, a);
		chk("index", res.index, i);
		chk("cov", res.cov, c);
		chk("list", res.list, l);
	endtask
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			error_cnt++;
			stop_test();
		end
	end
	initial
	begin
		req = 46'h0;
		req.byteenable = 4'hF;
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		rchk("bank0", 8'h00, 32'h0);
		bus(1'b1, 8'h2C, 32'hA5C35A3C);
		rchk("bank5", 8'h2C, 32'hA5C35A3C);
		req.byteenable <= 4'h2;
		bus(1'b1, 8'h2C, 32'h0);
		req.byteenable <= 4'hF;
		rchk("bank5 lane", 8'h2C, 32'hA5C3003C);
		bus(1'b1, 8'h44, 32'hFFFFFFFF);
		rchk("unmapped", 8'h44, 32'h0);
		bus(1'b1, CAFB_ADDR_SCALE, 32'h23);
		rchk("scale", CAFB_ADDR_SCALE, 32'h23);
		bus(1'b1, 8'h08, 32'hFF00FF24);
		bus(1'b1, 8'h0C, 32'hFF00FF00);
		bus(1'b1, 8'h10, 32'hFFFF6024);
		bus(1'b1, 8'h14, 32'hFFFF6024);
		bus(1'b1, CAFB_ADDR_ACTIVE, 32'h02);
		fchk(f_a, 1'b1, 6'h08, 2'h1, 1'b0);
		fchk(f_g, 1'b0, 6'h00, 2'h0, 1'b0);
		bus(1'b1, CAFB_ADDR_ACTIVE, 32'h06);
		fchk(f_a, 1'b1, 6'h10, 2'h2, 1'b0);
		fchk(f_h, 1'b1, 6'h08, 2'h1, 1'b0);
		bus(1'b1, CAFB_ADDR_ACTIVE, 32'h0);
		bus(1'b1, CAFB_ADDR_MODE, 32'h02);
		rchk("mode", CAFB_ADDR_MODE, 32'h02);
		bus(1'b1, CAFB_ADDR_ACTIVE, 32'h06);
		fchk(f_g, 1'b1, 6'h09, 2'h1, 1'b1);
		fchk(f_a, 1'b1, 6'h08, 2'h1, 1'b1);
		bus(1'b1, CAFB_ADDR_ACTIVE, 32'h0);
		bus(1'b1, CAFB_ADDR_SCALE, 32'h13);
		bus(1'b1, CAFB_ADDR_ACTIVE, 32'h04);
		fchk(f_h, 1'b1, 6'h14, 2'h1, 1'b0);
		bus(1'b1, CAFB_ADDR_ACTIVE, 32'h0);
		bus(1'b1, CAFB_ADDR_MODE, 32'h0402);
		bus(1'b1, CAFB_ADDR_ACTIVE, 32'h04);
		fchk(f_h, 1'b1, 6'h14, 2'h1, 1'b1);
		bus(1'b1, CAFB_ADDR_ACTIVE, 32'h0);
		bus(1'b1, 8'h00, pw(f_e));
		bus(1'b1, 8'h04, 32'hFFFFFFFF);
		bus(1'b1, CAFB_ADDR_ACTIVE, 32'h01);
		fchk(f_e, 1'b1, 6'h00, 2'h3, 1'b0);
		fchk(f_x, 1'b0, 6'h00, 2'h0, 1'b0);
		bus(1'b1, CAFB_ADDR_ACTIVE, 32'h0);
		bus(1'b1, 8'h04, 32'h00FFFFFF);
		bus(1'b1, CAFB_ADDR_ACTIVE, 32'h01);
		fchk(f_x, 1'b1, 6'h00, 2'h3, 1'b0);
		rchk("status", CAFB_ADDR_STATUS, 32'h3300);
		rchk("count", CAFB_ADDR_COUNT, 32'h0209);
		stop_test();
	end
endmodule
